// file: design/uab_defs.svh
// register offsets, field positions and timing constants of the auto-baud detector
`ifndef UAB_DEFS_SVH
`define UAB_DEFS_SVH

// ****************************************
// register map (byte addresses, one word each)
// ****************************************
`define UAB_ADDR_CTRL 8'h00
`define UAB_ADDR_DIV 8'h04
`define UAB_ADDR_RXDATA 8'h08
`define UAB_ADDR_STATUS 8'h0C
`define UAB_ADDR_IRQ_STAT 8'h10
`define UAB_ADDR_IRQ_MASK 8'h14

// ****************************************
// field positions
// ****************************************
`define UAB_CTRL_EN 0
`define UAB_CTRL_WAKE 1
`define UAB_CTRL_WIDE 2
`define UAB_CTRL_HS 3
`define UAB_CTRL_OVF 4
`define UAB_IRQ_DONE 0
`define UAB_IRQ_OVF 1
`define UAB_IRQ_W 2

// ****************************************
// values
// ****************************************
`define UAB_RESP_OKAY 2'h0
`define UAB_RESP_SLVERR 2'h2
`define UAB_DIV_RESET 16'h0000
`define UAB_CNT_START 16'h0001
`define UAB_CNT_MAX 16'hFFFF
`define UAB_EDGE_FIRST 3'h1
`define UAB_EDGE_LAST 3'h5
`define UAB_ABD_DIV_FAST 10'h020
`define UAB_ABD_DIV_MID 10'h080
`define UAB_ABD_DIV_SLOW 10'h200
`define UAB_SYNC_CHAR 8'h55
`define UAB_FRAME_BITS 5'h0A
`define UAB_BRK_FRAME_BITS 5'h18
`define UAB_BRK_LOW 13'h0000
`define UAB_IDLE_FILL 14'h3FFF

`endif

// file: design/uab_pkg.sv
// state types shared by the auto-baud detector and the sync sender
package uab_pkg;

    // measurement sequence of the detector
    typedef enum logic [2:0] {
        UAB_ST_IDLE = 3'b000,
        UAB_ST_WAIT_BREAK = 3'b001,
        UAB_ST_IN_BREAK = 3'b010,
        UAB_ST_WAIT_START = 3'b011,
        UAB_ST_WAIT_RISE = 3'b100,
        UAB_ST_MEASURE = 3'b101
    } uab_abd_state_t;

    // sender sequence
    typedef enum logic {
        UAB_TX_IDLE = 1'b0,
        UAB_TX_SEND = 1'b1
    } uab_tx_state_t;

endpackage : uab_pkg

// file: design/uab_link_if.sv
// serial line between the remote sync sender and the auto-baud detector
`timescale 1ns/1ps
interface uab_link_if;
    logic rx_line;

    modport dev (input rx_line);
    modport sender (output rx_line);
endinterface : uab_link_if

// file: design/uab_sync.sv
// two flip-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module uab_sync
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // line idles high, so both stages reset high to avoid a false edge
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : uab_sync

// file: design/uab_sender.sv
// remote sender: optional break, then the 55h sync character
`timescale 1ns/1ps
`include "uab_defs.svh"
module uab_sender
    import uab_pkg::*;
#(
    parameter int BIT_CYCLES = 347
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial line
    uab_link_if.sender link,
    // user side
    input wire logic send,
    input wire logic with_break,
    output logic busy
);
    uab_tx_state_t state_q, state_d;
    logic [23:0] shift_q, shift_d;
    logic [4:0] bits_q, bits_d;
    logic [15:0] cnt_q, cnt_d;
    logic line_q, line_d;

    assign link.rx_line = line_q;
    assign busy = (state_q == UAB_TX_SEND);

    // frame sequencing, bits go out lsb first
    always_comb
    begin
        state_d = state_q;
        shift_d = shift_q;
        bits_d = bits_q;
        cnt_d = cnt_q;
        line_d = line_q;
        unique case (state_q)
            UAB_TX_IDLE:
            begin
                line_d = 1'b1;
                if (send)
                begin
                    // the sync character always ends on a stop bit, giving the fifth rise
                    if (with_break)
                    begin
                        shift_d = {1'b1, `UAB_SYNC_CHAR, 1'b0, 1'b1, `UAB_BRK_LOW};
                        bits_d = `UAB_BRK_FRAME_BITS;
                    end
                    else
                    begin
                        // start bit sits in the lsb so the line drops as soon as busy rises
                        shift_d = {`UAB_IDLE_FILL, 1'b1, `UAB_SYNC_CHAR, 1'b0};
                        bits_d = `UAB_FRAME_BITS;
                    end
                    line_d = shift_d[0];
                    shift_d = shift_d >> 1;
                    cnt_d = 16'h0000;
                    state_d = UAB_TX_SEND;
                end
            end
            UAB_TX_SEND:
            begin
                cnt_d = cnt_q + 16'h0001;
                if (cnt_q == 16'(BIT_CYCLES - 1))
                begin
                    cnt_d = 16'h0000;
                    bits_d = bits_q - 5'h01;
                    line_d = shift_q[0];
                    shift_d = shift_q >> 1;
                    if (bits_q == 5'h01)
                    begin
                        line_d = 1'b1;
                        state_d = UAB_TX_IDLE;
                    end
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= UAB_TX_IDLE;
            shift_q <= 24'h000000;
            bits_q <= 5'h00;
            cnt_q <= 16'h0000;
            line_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            shift_q <= shift_d;
            bits_q <= bits_d;
            cnt_q <= cnt_d;
            line_q <= line_d;
        end
    end
endmodule : uab_sender

// file: design/uab_detector.sv
// auto-baud detector with its axi4-lite register file and interrupt
`timescale 1ns/1ps
`include "uab_defs.svh"
module uab_detector
    import uab_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial line
    uab_link_if.dev link,
    // axi4-lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // status
    output logic receive_idle,
    output logic irq
);
    // ****************************************
    // helpers
    // ****************************************

    // measurement tick period in core clocks, eight base clocks
    function automatic logic [9:0] uab_abd_div(input logic wide, input logic hs);
        if (wide && hs)
            return `UAB_ABD_DIV_FAST;
        else if (wide || hs)
            return `UAB_ABD_DIV_MID;
        else
            return `UAB_ABD_DIV_SLOW;
    endfunction : uab_abd_div

    function automatic logic uab_mapped(input logic [7:0] addr);
        return addr == `UAB_ADDR_CTRL || addr == `UAB_ADDR_DIV || addr == `UAB_ADDR_RXDATA ||
               addr == `UAB_ADDR_STATUS || addr == `UAB_ADDR_IRQ_STAT || addr == `UAB_ADDR_IRQ_MASK;
    endfunction : uab_mapped

    // ****************************************
    // state
    // ****************************************
    logic rx_s, rx_prev_q;
    logic rise, fall;
    uab_abd_state_t state_q, state_d;
    logic en_q, en_d, wake_q, wake_d, wide_q, wide_d, hs_q, hs_d, ovf_q, ovf_d;
    logic [15:0] div_q, div_d;
    logic [9:0] presc_q, presc_d;
    logic [2:0] edges_q, edges_d;
    logic rflag_q, rflag_d;
    logic [`UAB_IRQ_W-1:0] istat_q, istat_d, imask_q, imask_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

    // metastability is kept away from the edge detector
    uab_sync u_rx_sync
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(link.rx_line),
        .sync_out(rx_s)
    );

    assign rise = rx_s && !rx_prev_q;
    assign fall = !rx_s && rx_prev_q;
    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready = !w_got_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    // the normal receiver may only run while no measurement is armed
    assign receive_idle = en_q;
    assign irq = |(istat_q & imask_q);

    // ****************************************
    // next-state logic: measurement, then bus accesses
    // ****************************************
    always_comb
    begin
        logic wr, rd;
        wr = aw_got_q && w_got_q && !bvalid_q;
        rd = s_axi_arvalid && !rvalid_q;
        state_d = state_q;
        en_d = en_q;
        wake_d = wake_q;
        wide_d = wide_q;
        hs_d = hs_q;
        ovf_d = ovf_q;
        div_d = div_q;
        presc_d = presc_q;
        edges_d = edges_q;
        rflag_d = rflag_q;
        istat_d = istat_q;
        imask_d = imask_q;
        aw_got_d = aw_got_q;
        aw_addr_d = aw_addr_q;
        w_got_d = w_got_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q && !s_axi_rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;

        // software clear of the enable aborts any step
        unique case (state_q)
            UAB_ST_IDLE:
                if (en_q)
                    state_d = wake_q ? UAB_ST_WAIT_BREAK : UAB_ST_WAIT_START;
            UAB_ST_WAIT_BREAK:
                if (fall)
                    state_d = UAB_ST_IN_BREAK;
            UAB_ST_IN_BREAK:
                if (rise)
                begin
                    wake_d = 1'b0; // end of break, measure the next byte
                    state_d = UAB_ST_WAIT_START;
                end
            UAB_ST_WAIT_START:
                if (fall)
                    state_d = UAB_ST_WAIT_RISE;
            UAB_ST_WAIT_RISE:
                if (rise)
                begin
                    div_d = `UAB_CNT_START;
                    presc_d = 10'h000;
                    edges_d = `UAB_EDGE_FIRST;
                    state_d = UAB_ST_MEASURE;
                end
            UAB_ST_MEASURE:
            begin
                presc_d = presc_q + 10'h001;
                if (presc_q == uab_abd_div(wide_q, hs_q) - 10'h001)
                begin
                    presc_d = 10'h000;
                    div_d = div_q + 16'h0001; // full 16 bits whatever the width select
                    if (div_q == `UAB_CNT_MAX)
                    begin
                        ovf_d = 1'b1;
                        istat_d[`UAB_IRQ_OVF] = 1'b1;
                    end
                end
                if (rise)
                begin
                    edges_d = edges_q + 3'h1;
                    if (edges_q == `UAB_EDGE_LAST - 3'h1)
                    begin
                        div_d = div_q; // count stays in the divisor pair
                        en_d = 1'b0;
                        rflag_d = 1'b1;
                        istat_d[`UAB_IRQ_DONE] = 1'b1;
                        state_d = UAB_ST_IDLE;
                    end
                end
            end
            default:
                state_d = UAB_ST_IDLE;
        endcase
        if (!en_q)
            state_d = UAB_ST_IDLE;

        // capture address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end

        // register write once both halves are held
        if (wr)
        begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = uab_mapped(aw_addr_q) ? `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
            if (aw_addr_q == `UAB_ADDR_CTRL && w_strb_q[0])
            begin
                en_d = w_data_q[`UAB_CTRL_EN];
                wake_d = w_data_q[`UAB_CTRL_WAKE];
                wide_d = w_data_q[`UAB_CTRL_WIDE];
                hs_d = w_data_q[`UAB_CTRL_HS];
                // overflow clears only once enable is already low; a new overflow wins
                if (!w_data_q[`UAB_CTRL_OVF] && !en_q && !(ovf_d && !ovf_q))
                    ovf_d = 1'b0;
            end
            // the pair is the live counter during measurement, so writes are dropped while enable is set
            if (aw_addr_q == `UAB_ADDR_DIV && !en_q)
            begin
                if (w_strb_q[0])
                    div_d[7:0] = w_data_q[7:0];
                if (w_strb_q[1])
                    div_d[15:8] = w_data_q[15:8];
            end
            if (aw_addr_q == `UAB_ADDR_IRQ_STAT && w_strb_q[0])
                istat_d = istat_d & ~(w_data_q[`UAB_IRQ_W-1:0] & ~(istat_d & ~istat_q));
            if (aw_addr_q == `UAB_ADDR_IRQ_MASK && w_strb_q[0])
                imask_d = w_data_q[`UAB_IRQ_W-1:0];
        end

        // register read, answered one cycle after the address is taken
        if (rd)
        begin
            rvalid_d = 1'b1;
            rresp_d = uab_mapped(s_axi_araddr) ? `UAB_RESP_OKAY : `UAB_RESP_SLVERR;
            rdata_d = 32'h00000000;
            unique case (s_axi_araddr)
                `UAB_ADDR_CTRL:
                    rdata_d[`UAB_CTRL_OVF:0] = {ovf_q, hs_q, wide_q, wake_q, en_q};
                `UAB_ADDR_DIV:
                    rdata_d[15:0] = div_q;
                `UAB_ADDR_RXDATA:
                    if (!(rflag_d && !rflag_q))
                        rflag_d = 1'b0; // content is discarded by software
                `UAB_ADDR_STATUS:
                    rdata_d[2:0] = {state_q == UAB_ST_MEASURE, en_q, rflag_q};
                `UAB_ADDR_IRQ_STAT:
                    rdata_d[`UAB_IRQ_W-1:0] = istat_q;
                `UAB_ADDR_IRQ_MASK:
                    rdata_d[`UAB_IRQ_W-1:0] = imask_q;
                default:
                    rdata_d = 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_prev_q <= 1'b1;
            state_q <= UAB_ST_IDLE;
            en_q <= 1'b0;
            wake_q <= 1'b0;
            wide_q <= 1'b0;
            hs_q <= 1'b0;
            ovf_q <= 1'b0;
            div_q <= `UAB_DIV_RESET;
            presc_q <= 10'h000;
            edges_q <= 3'h0;
            rflag_q <= 1'b0;
            istat_q <= '0;
            imask_q <= '0;
            aw_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_got_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `UAB_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= `UAB_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            rx_prev_q <= rx_s;
            state_q <= state_d;
            en_q <= en_d;
            wake_q <= wake_d;
            wide_q <= wide_d;
            hs_q <= hs_d;
            ovf_q <= ovf_d;
            div_q <= div_d;
            presc_q <= presc_d;
            edges_q <= edges_d;
            rflag_q <= rflag_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
            aw_got_q <= aw_got_d;
            aw_addr_q <= aw_addr_d;
            w_got_q <= w_got_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end
endmodule : uab_detector

// file: tb/uab_detector_chk.sv
// concurrent checks on the serial line and the detector's bus and status ports
`timescale 1ns/1ps
module uab_detector_chk
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link and sender
    input wire logic rx_line,
    input wire logic busy,
    // detector bus ports
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // status
    input wire logic receive_idle,
    input wire logic irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // ****************************************
    // steps
    // ****************************************
    sequence s_write_ack;
        $rose(s_axi_bvalid);
    endsequence
    sequence s_start_low;
        !rx_line ##1 !rx_line;
    endsequence

    // ****************************************
    // checks
    // ****************************************
    AST_ARM_BY_WRITE: assert property ($rose(receive_idle) |-> s_write_ack)
        else $error("receiver held idle without a register write");
    AST_END_FLAGGED: assert property ($fell(receive_idle) |-> irq || $rose(s_axi_bvalid))
        else $error("measurement ended without flag or abort");
    AST_LINE_IDLE: assert property (!busy |-> rx_line)
        else $error("line low while sender idle");
    AST_START_BIT: assert property ($rose(busy) |-> s_start_low)
        else $error("frame does not open with a low bit");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    // the main completion must be seen at least once
    cover property ($fell(receive_idle) && irq);
endmodule : uab_detector_chk

// file: tb/uart_auto_baud_detect_tb.sv
// testbench: sync sender facing the auto-baud detector, driven over axi4-lite
`timescale 1ns/1ps
`include "uab_defs.svh"
module uart_auto_baud_detect_tb;
    // short bit time keeps each frame under two thousand cycles, yet the measured eight bits span more than every tick period
    localparam int BC = 66;
    logic core_clk, rst_n, send, with_break;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, receive_idle, irq, busy;
    logic [31:0] ctrl;
    int tick, failures, samples_checked;
    bit wk, wide, hs;

    uab_link_if link_bus();
    uab_detector i_uab_detector(.core_clk, .rst_n, .link(link_bus), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .receive_idle, .irq);
    uab_sender #(.BIT_CYCLES(BC)) i_uab_sender(.core_clk, .rst_n, .link(link_bus), .send,
        .with_break, .busy);
    uab_detector_chk i_chk(.core_clk, .rst_n, .rx_line(link_bus.rx_line), .busy, .s_axi_awready,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
        .s_axi_rvalid, .s_axi_rready, .receive_idle, .irq);

    // clock generator
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ****************************************
    // compare and report
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic hang(input string nm);
        failures++;
        $display("ERROR %s expected answer seen timeout", nm);
        close_out();
    endtask : hang

    // ****************************************
    // bus cycles: ready is read at the falling edge, so it is the value the next rising edge samples
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        bit got;
        got = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 100 && !got; n++)
        begin
            @(negedge core_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
            got = tb;
        end
        if (!got) hang("bresp");
        chk("bresp", 32'(er), 32'(r));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        logic [1:0] r;
        logic [31:0] d;
        bit got;
        got = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 100 && !got; n++)
        begin
            @(negedge core_clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
            got = tr;
        end
        if (!got) hang("rresp");
        chk("rresp", 32'(er), 32'(r));
        chk("rdata", ed, d);
    endtask : rd

    // one frame from the far end, waited on by the sender's busy
    task automatic sync_send(input bit wb);
        bit done;
        done = 0;
        @(posedge core_clk);
        send <= 1'b1;
        with_break <= wb;
        @(posedge core_clk);
        send <= 1'b0;
        for (int n = 0; n < 3000 && !done; n++)
        begin
            @(negedge core_clk);
            done = !busy;
        end
        if (!done) hang("busy");
    endtask : sync_send

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {rst_n, send, with_break, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`UAB_ADDR_CTRL, 32'h0, `UAB_RESP_OKAY); // control after reset
        rd(`UAB_ADDR_DIV, 32'h0, `UAB_RESP_OKAY); // divisor after reset
        rd(`UAB_ADDR_STATUS, 32'h0, `UAB_RESP_OKAY); // no flag after reset
        chk("irq", 32'h0, 32'(irq)); // quiet after reset
        wr(8'h40, 32'h1, `UAB_RESP_SLVERR); // unmapped write
        rd(8'h40, 32'h0, `UAB_RESP_SLVERR); // unmapped read
        // an abort before any edge must leave the preset divisor alone
        wr(`UAB_ADDR_DIV, 32'h1234, `UAB_RESP_OKAY); // preset divisor
        wr(`UAB_ADDR_CTRL, 32'h1, `UAB_RESP_OKAY); // arm
        chk("receive_idle", 32'h1, 32'(receive_idle)); // receiver held idle
        wr(`UAB_ADDR_DIV, 32'hABCD, `UAB_RESP_OKAY); // ignored while armed
        wr(`UAB_ADDR_CTRL, 32'h0, `UAB_RESP_OKAY); // abort
        wr(`UAB_ADDR_CTRL, 32'h0, `UAB_RESP_OKAY); // overflow clear after enable
        rd(`UAB_ADDR_DIV, 32'h1234, `UAB_RESP_OKAY); // divisor untouched
        rd(`UAB_ADDR_CTRL, 32'h0, `UAB_RESP_OKAY); // no overflow, disarmed
        wr(`UAB_ADDR_IRQ_MASK, 32'h3, `UAB_RESP_OKAY); // unmask both events
        // every select pair, then wake with a break in front of the sync
        for (int i = 0; i < 5; i++)
        begin
            wk = (i == 4);
            wide = (i == 0 || i == 1 || i == 4);
            hs = (i == 0 || i == 2 || i == 4);
            tick = (wide && hs) ? `UAB_ABD_DIV_FAST : (wide || hs) ? `UAB_ABD_DIV_MID : `UAB_ABD_DIV_SLOW;
            ctrl = 32'(hs) << `UAB_CTRL_HS | 32'(wide) << `UAB_CTRL_WIDE;
            wr(`UAB_ADDR_CTRL, ctrl | 32'(wk) << `UAB_CTRL_WAKE | 32'h1, `UAB_RESP_OKAY); // arm
            rd(`UAB_ADDR_STATUS, 32'h2, `UAB_RESP_OKAY); // armed, not measuring
            sync_send(wk);
            repeat (8) @(posedge core_clk);
            rd(`UAB_ADDR_DIV, 32'(1 + 8 * BC / tick), `UAB_RESP_OKAY); // count
            rd(`UAB_ADDR_CTRL, ctrl, `UAB_RESP_OKAY); // enable and wake cleared
            chk("receive_idle", 32'h0, 32'(receive_idle)); // receiver released
            rd(`UAB_ADDR_STATUS, 32'h1, `UAB_RESP_OKAY); // flag set
            chk("irq", 32'h1, 32'(irq)); // done raised
            wr(`UAB_ADDR_IRQ_MASK, 32'h0, `UAB_RESP_OKAY); // mask
            chk("irq", 32'h0, 32'(irq)); // masked
            wr(`UAB_ADDR_IRQ_MASK, 32'h3, `UAB_RESP_OKAY); // unmask
            rd(`UAB_ADDR_RXDATA, 32'h0, `UAB_RESP_OKAY); // discard read
            rd(`UAB_ADDR_STATUS, 32'h0, `UAB_RESP_OKAY); // flag cleared by read
            rd(`UAB_ADDR_IRQ_STAT, 32'h1, `UAB_RESP_OKAY); // done only, no overflow
            wr(`UAB_ADDR_IRQ_STAT, 32'h1, `UAB_RESP_OKAY); // write one clears
            chk("irq", 32'h0, 32'(irq)); // cleared
        end
        close_out();
    end
endmodule : uart_auto_baud_detect_tb
